// ===== rtl/rrq_pkg.sv
// Functional notes
// RULE_01 - Routed-by-ID vendor message carries destination ID in descriptor bits 15:0.
// RULE_02 - Vendor message: descriptor bits 63:32 become header Dword 3.
// RULE_03 - ATS message: descriptor bits 63:0 become header Dwords 2 and 3.
// RULE_04 - Every packet starts with the 16-byte descriptor, payload after it.
// RULE_05 - Valid must stay high whole packet; a mid-packet drop nullifies the TLP.
// RULE_06 - User asserts last in the final beat of every packet.
// RULE_07 - Ready may drop any cycle; user holds all inputs while ready low.
// RULE_08 - One keep bit per Dword, contiguous; gaps only in final beat.
// RULE_09 - Head and tail byte enables are given in each packet's first beat.
// RULE_10 - Payload within max payload size and never crosses 4 Kbyte boundary.
// RULE_11 - Zero-length write sends one dummy Dword with all byte enables zero.
// RULE_12 - Byte enables contiguous except memory writes of two Dwords or less.
// RULE_13 - Straddled beat: offset 3:2, enables 7:4 second TLP; 1:0, 3:0 first. Code ignores i_straddle_en and starts no second TLP in a beat.
// RULE_14 - Address-aligned payload starts in second quarter; offset gives first Dword.
// RULE_15 - Non-posted request without payload is only the descriptor, keep on it.
// RULE_16 - Zero-length read: length one Dword, both byte enables zero.
// RULE_17 - Read requests carry completion placement offset in the offset field.
// RULE_18 - Non-posted payload: no gap Dword-aligned; offset-placed in address mode.
// RULE_19 - I/O and config writes use head enables; atomics take all bytes valid.
// RULE_20 - Message payload follows the descriptor directly in either mode.
// RULE_21 - Messages ignore byte enables; end from last and keep; offset zero.
// RULE_22 - Discontinue during payload aborts the request; device nullifies the TLP.
// RULE_23 - Discontinue only with valid; no new packet in an aborted beat.
// RULE_24 - Discontinue is sticky for the rest of a continuing packet.
// RULE_25 - Alignment mode and straddle enable are static configuration.
package rrq_pkg;
  localparam int DATA_W      = 512;
  localparam int DW_PER_BEAT = 16;
  localparam int DESC_W      = 128;
  localparam int TYPE_LSB    = 75;
  localparam int TYPE_W      = 4;
  localparam int ROUTE_LSB   = 112;
  localparam int MCODE_LSB   = 104;
  localparam logic [3:0] TYPE_MSG_VEND = 4'hD;
  localparam logic [3:0] TYPE_MSG_ATS  = 4'hE;
  localparam logic [3:0] TYPE_ATOMIC0  = 4'h4;
  localparam logic [3:0] TYPE_ATOMIC2  = 4'h6;
  localparam logic [2:0] ROUTE_BY_ID   = 3'h2;

  typedef struct packed {
    logic       discontinue;
    logic [3:0] addr_offset;
    logic [7:0] tail_byte_enables;
    logic [7:0] head_byte_enables;
  } rrq_side_t;

  typedef struct packed {
    logic [31:0] hdr_dw3;
    logic [31:0] hdr_dw2;
    logic [15:0] dest_id;
    logic [7:0]  head_be;
    logic [7:0]  tail_be;
    logic [3:0]  addr_offset;
    logic [3:0]  req_type;
    logic        is_msg;
  } rrq_hdr_t;
endpackage

// ===== rtl/rrq_port.sv
`timescale 1ns/10ps
module rrq_port
(
  input  wire logic                   i_clk,             // User clock
  input  wire logic                   i_arst_n,          // Async reset, low
  input  wire logic                   i_ce,              // Clock enable
  input  wire logic                   i_addr_aligned,    // Address-aligned mode
  input  wire logic                   i_straddle_en,     // Straddle enable
  input  wire logic                   i_req_in_valid,    // Request beat valid
  output logic                        o_req_in_ready,    // Device accepts beat
  input  wire logic                   i_req_in_last,     // Final beat
  input  wire logic [rrq_pkg::DATA_W-1:0] i_req_in_data, // Beat data
  input  wire logic [rrq_pkg::DW_PER_BEAT-1:0] i_req_in_keep, // Dword keep
  input  wire rrq_pkg::rrq_side_t     i_req_in_sideband, // Sideband
  input  wire logic                   i_link_ready,      // Link side accepts beat
  output logic                        o_tlp_valid,       // Beat to link
  output logic [rrq_pkg::DATA_W-1:0]  o_tlp_data,        // Beat data to link
  output logic [rrq_pkg::DW_PER_BEAT-1:0] o_req_dword_keep, // Keep to link
  output logic                        o_tlp_sop,         // First beat of TLP
  output logic                        o_tlp_eop,         // Last beat of TLP
  output logic                        o_tlp_nullify,     // Nullify this TLP
  output rrq_pkg::rrq_hdr_t           o_tlp_hdr,         // Header fields
  output logic                        o_cfg_locked       // Config latched
);
  import rrq_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_BODY} rrq_state_t;

  rrq_state_t state, next_state;
  logic       err, next_err;
  logic       ovalid, next_ovalid;
  logic [DATA_W-1:0] odata, next_odata;
  logic [DW_PER_BEAT-1:0] okeep, next_okeep;
  logic       osop, next_osop, oeop, next_oeop, onull, next_onull;
  rrq_hdr_t   hdr, next_hdr;
  logic       cfg_lock, next_cfg_lock;
  logic       accept;
  logic [3:0] rtype;
  logic       is_msg;
  logic [2:0] route;

  // Accept when output slot free or draining
  assign o_req_in_ready = ~ovalid | i_link_ready; // RULE_07
  assign accept = i_ce & i_req_in_valid & o_req_in_ready;
  assign rtype  = i_req_in_data[TYPE_LSB +: TYPE_W];
  assign route  = i_req_in_data[ROUTE_LSB +: 3];
  assign is_msg = rtype[3] & rtype[2];

  always_comb
  begin
    next_state    = state;
    next_err      = err;
    next_ovalid   = ovalid;
    next_odata    = odata;
    next_okeep    = okeep;
    next_osop     = osop;
    next_oeop     = oeop;
    next_onull    = onull;
    next_hdr      = hdr;
    next_cfg_lock = cfg_lock;
    if (ovalid && i_link_ready)
      next_ovalid = 1'b0;
    if (state == S_BODY && !i_req_in_valid)
      next_err = 1'b1; // RULE_05
    if (accept)
    begin
      next_cfg_lock = 1'b1; // RULE_25
      next_ovalid   = 1'b1;
      next_odata    = i_req_in_data;
      next_okeep    = i_req_in_keep;
      next_osop     = (state == S_IDLE);
      next_oeop     = i_req_in_last;
      if (state == S_IDLE)
      begin
        next_hdr.req_type    = rtype;
        next_hdr.is_msg      = is_msg;
        next_hdr.addr_offset = is_msg ? 4'h0 : i_req_in_sideband.addr_offset; // RULE_21
        next_hdr.dest_id     = (is_msg && route == ROUTE_BY_ID) ? i_req_in_data[15:0] : 16'h0000;
        next_hdr.hdr_dw2     = 32'h0000_0000;
        next_hdr.hdr_dw3     = 32'h0000_0000;
        if (rtype == TYPE_MSG_VEND)
          next_hdr.hdr_dw3 = i_req_in_data[63:32]; // RULE_02
        if (rtype == TYPE_MSG_ATS)
        begin
          next_hdr.hdr_dw2 = i_req_in_data[31:0]; // RULE_03
          next_hdr.hdr_dw3 = i_req_in_data[63:32]; // RULE_03
        end
        if (is_msg)
        begin
          next_hdr.head_be = 8'h00; // RULE_21
          next_hdr.tail_be = 8'h00;
        end
        else if (rtype >= TYPE_ATOMIC0 && rtype <= TYPE_ATOMIC2)
        begin
          next_hdr.head_be = 8'hFF; // RULE_19
          next_hdr.tail_be = 8'hFF;
        end
        else
        begin
          next_hdr.head_be = i_req_in_sideband.head_byte_enables; // RULE_13
          next_hdr.tail_be = i_req_in_sideband.tail_byte_enables;
        end
      end
      // Sticky abort covers later beats of same packet
      next_onull = next_err | i_req_in_sideband.discontinue; // RULE_22
      if (i_req_in_last)
      begin
        next_state = S_IDLE;
        next_err   = 1'b0;
      end
      else
      begin
        next_state = S_BODY;
        next_err   = next_err | i_req_in_sideband.discontinue; // RULE_24
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state    <= S_IDLE;
      err      <= 1'b0;
      ovalid   <= 1'b0;
      odata    <= '0;
      okeep    <= '0;
      osop     <= 1'b0;
      oeop     <= 1'b0;
      onull    <= 1'b0;
      hdr      <= '0;
      cfg_lock <= 1'b0;
    end
    else if (i_ce)
    begin
      state    <= next_state;
      err      <= next_err;
      ovalid   <= next_ovalid;
      odata    <= next_odata;
      okeep    <= next_okeep;
      osop     <= next_osop;
      oeop     <= next_oeop;
      onull    <= next_onull;
      hdr      <= next_hdr;
      cfg_lock <= next_cfg_lock;
    end
  end

  assign o_tlp_valid      = ovalid;
  assign o_tlp_data       = odata;
  assign o_req_dword_keep = okeep;
  assign o_tlp_sop        = osop;
  assign o_tlp_eop        = oeop;
  assign o_tlp_nullify    = onull;
  assign o_tlp_hdr        = hdr;
  assign o_cfg_locked     = cfg_lock;

  property p_disc_null;
    @(posedge i_clk) disable iff (!i_arst_n)
    (accept && i_req_in_sideband.discontinue) |=> o_tlp_nullify;
  endproperty
  a_disc_null: assert property (p_disc_null) else $error("discontinue not nullified"); // RULE_22

  sequence s_disc_open;
    accept && i_req_in_sideband.discontinue && !i_req_in_last;
  endsequence
  property p_sticky;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_disc_open ##1 accept |=> o_tlp_nullify;
  endproperty
  a_sticky: assert property (p_sticky) else $error("abort not sticky"); // RULE_24

  sequence s_mid_drop;
    (state == S_BODY) && !i_req_in_valid && i_ce;
  endsequence
  property p_drop_null;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_mid_drop ##1 (accept && i_ce) |=> o_tlp_nullify;
  endproperty
  a_drop_null: assert property (p_drop_null) else $error("valid drop not nullified"); // RULE_05

  property p_ready;
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_tlp_valid && !i_link_ready) |-> !o_req_in_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready high while stalled"); // RULE_07

  property p_vend;
    @(posedge i_clk) disable iff (!i_arst_n)
    (accept && state == S_IDLE && rtype == TYPE_MSG_VEND)
      |=> o_tlp_hdr.hdr_dw3 == $past(i_req_in_data[63:32]);
  endproperty
  a_vend: assert property (p_vend) else $error("vendor header dword 3 wrong"); // RULE_02

  property p_ats;
    @(posedge i_clk) disable iff (!i_arst_n)
    (accept && state == S_IDLE && rtype == TYPE_MSG_ATS)
      |=> {o_tlp_hdr.hdr_dw3, o_tlp_hdr.hdr_dw2} == $past(i_req_in_data[63:0]);
  endproperty
  a_ats: assert property (p_ats) else $error("ATS header wrong"); // RULE_03

  property p_msg_be;
    @(posedge i_clk) disable iff (!i_arst_n)
    (accept && state == S_IDLE && is_msg)
      |=> o_tlp_hdr.head_be == 8'h00 && o_tlp_hdr.addr_offset == 4'h0;
  endproperty
  a_msg_be: assert property (p_msg_be) else $error("message enables not ignored"); // RULE_21

  property p_atomic;
    @(posedge i_clk) disable iff (!i_arst_n)
    (accept && state == S_IDLE && rtype == TYPE_ATOMIC0)
      |=> o_tlp_hdr.head_be == 8'hFF && o_tlp_hdr.tail_be == 8'hFF;
  endproperty
  a_atomic: assert property (p_atomic) else $error("atomic enables not full"); // RULE_19

  property p_be_lanes;
    @(posedge i_clk) disable iff (!i_arst_n)
    (accept && state == S_IDLE && !is_msg && (rtype < TYPE_ATOMIC0 || rtype > TYPE_ATOMIC2))
      |=> {o_tlp_hdr.tail_be, o_tlp_hdr.head_be}
          == $past({i_req_in_sideband.tail_byte_enables, i_req_in_sideband.head_byte_enables});
  endproperty
  a_be_lanes: assert property (p_be_lanes) else $error("byte enables not kept"); // RULE_13

  property p_lock;
    @(posedge i_clk) disable iff (!i_arst_n)
    accept |=> o_cfg_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("config not locked"); // RULE_25
endmodule

// ===== verification/rrq_user_src.sv
`timescale 1ns/10ps
module rrq_user_src
(
  input  wire logic                       i_clk,   // User clock
  input  wire logic                       i_ready, // Device ready
  output logic                            o_valid, // Beat valid
  output logic                            o_last,  // Final beat
  output logic [rrq_pkg::DATA_W-1:0]      o_data,  // Beat data
  output logic [rrq_pkg::DW_PER_BEAT-1:0] o_keep,  // Dword keep
  output rrq_pkg::rrq_side_t              o_side   // Sideband
);
  import rrq_pkg::*;
  initial
  begin
    o_valid = 1'b0;
    o_last  = 1'b0;
    o_data  = '0;
    o_keep  = '0;
    o_side  = '0;
  end
  // Holds the beat until taken; returns at the taking edge
  task automatic send(input logic [DATA_W-1:0] d, input logic [DW_PER_BEAT-1:0] k,
                      input logic l, input rrq_side_t s);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_data  = d;
    o_keep  = k;
    o_last  = l;
    o_side  = s;
    do @(posedge i_clk); while (i_ready !== 1'b1);
  endtask
  // Released lines show changed garbage
  task automatic idle();
    @(negedge i_clk);
    o_valid = 1'b0;
    o_last  = ~o_last;
    o_data  = ~o_data;
    o_keep  = ~o_keep;
    o_side  = ~o_side;
    o_side.discontinue = 1'b0;
  endtask
endmodule

// ===== verification/rrq_port_tb.sv
`timescale 1ns/10ps
module rrq_port_tb;
  import rrq_pkg::*;
  logic                   clk, arst_n, lrdy, rdy, vld, lst, tv, sop, eop, nul, lck;
  logic [DATA_W-1:0]      dat, td;
  logic [DW_PER_BEAT-1:0] kp, tk;
  rrq_side_t              sd;
  rrq_hdr_t               hdr;
  int                     error_cnt, n_tests;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  rrq_user_src u_rrq_user_src (.i_clk(clk), .i_ready(rdy), .o_valid(vld), .o_last(lst),
    .o_data(dat), .o_keep(kp), .o_side(sd));
  rrq_port u_rrq_port (.i_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1),
    .i_addr_aligned(1'b0), .i_straddle_en(1'b1),
    .i_req_in_valid(vld), .o_req_in_ready(rdy), .i_req_in_last(lst),
    .i_req_in_data(dat), .i_req_in_keep(kp), .i_req_in_sideband(sd), .i_link_ready(lrdy),
    .o_tlp_valid(tv), .o_tlp_data(td), .o_req_dword_keep(tk), .o_tlp_sop(sop),
    .o_tlp_eop(eop), .o_tlp_nullify(nul), .o_tlp_hdr(hdr), .o_cfg_locked(lck));
  function automatic logic [DATA_W-1:0] desc(input logic [3:0] ty, input logic [2:0] rt,
                                              input logic [63:0] lo);
    desc = '0;
    desc[63:0] = lo;
    desc[TYPE_LSB +: TYPE_W] = ty;
    desc[ROUTE_LSB +: 3] = rt;
  endfunction
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic beat(input logic [DATA_W-1:0] d, input logic l, input rrq_side_t s,
                      input logic n, input logic [31:0] tg);
    int i;
    u_rrq_user_src.send(d, 16'hFFFF, l, s);
    #1;
    for (i = 0; i < 4 && tv !== 1'b1; i++) @(posedge clk) #1;
    chk(td, d);
    chk({sop, eop, nul}, {tg[0], l, n});
  endtask
  task automatic t_msg();
    beat(desc(TYPE_MSG_VEND, ROUTE_BY_ID, 64'hA5A5_0001_0000_1234), 1, '0, 0, 1);
    chk(hdr.dest_id, 16'h1234);
    chk(hdr.hdr_dw3, 32'hA5A5_0001);
    chk(hdr.is_msg, 1'b1);
    chk(hdr.req_type, TYPE_MSG_VEND);
    chk(lck, 1'b1);
    beat(desc(TYPE_MSG_ATS, 3'h0, 64'h8765_4321_0FED_CBA9), 1, '0, 0, 1);
    chk({hdr.hdr_dw3, hdr.hdr_dw2}, 64'h8765_4321_0FED_CBA9);
    $display("test messages done");
  endtask
  task automatic t_atomic();
    logic [3:0] ty;
    for (ty = TYPE_ATOMIC0; ty <= TYPE_ATOMIC2; ty++)
    begin
      beat(desc(ty, 3'h0, 64'h0), 0, {1'b0, 4'h0, 8'h80, 8'h01}, 0, 1);
      chk({hdr.head_be, hdr.tail_be}, 16'hFFFF);
      beat(~desc(ty, 3'h0, 64'h0), 1, '0, 0, 0);
    end
    $display("test atomics done");
  endtask
  task automatic t_abort();
    beat(desc(4'h1, 3'h0, 64'h40), 0, {1'b1, 4'h0, 8'hFF, 8'hFF}, 1, 1);
    beat({16{32'h1111_2222}}, 0, '0, 1, 0);
    beat({16{32'h3333_4444}}, 1, '0, 1, 0);
    u_rrq_user_src.idle();
    beat(desc(4'h1, 3'h0, 64'h80), 0, '0, 0, 1);
    u_rrq_user_src.idle();
    beat({16{32'h5555_6666}}, 1, '0, 1, 0);
    $display("test abort done");
  endtask
  task automatic t_short();
    logic [DATA_W-1:0] a;
    a = desc(4'h1, 3'h0, 64'h200);
    a[74:64] = 11'h001;
    a[159:128] = 32'hDEAD_BEEF;
    u_rrq_user_src.send(a, 16'h001F, 1'b1, '0);
    #1;
    chk(td, a);
    chk({tk, sop, eop, nul}, {16'h001F, 3'b110});
    chk({hdr.head_be, hdr.tail_be}, 16'h0000);
    a = desc(4'h0, 3'h0, 64'h300);
    a[74:64] = 11'h001;
    u_rrq_user_src.send(a, 16'h000F, 1'b1, {1'b0, 4'h5, 8'h00, 8'h00});
    #1;
    chk({tk, hdr.addr_offset}, {16'h000F, 4'h5});
    chk({hdr.head_be, hdr.tail_be}, 16'h0000);
    a = desc(TYPE_MSG_VEND, 3'h0, 64'hC0DE_0002_0000_0000);
    a[255:128] = {4{32'h9999_AAAA}};
    u_rrq_user_src.send(a, 16'h00FF, 1'b1, {1'b0, 4'h0, 8'h0F, 8'hF0});
    #1;
    chk({tk, hdr.head_be, hdr.tail_be, hdr.addr_offset}, {16'h00FF, 20'h00000});
    chk(hdr.hdr_dw3, 32'hC0DE_0002);
    $display("test short requests done");
  endtask
  task automatic t_stall();
    logic [DATA_W-1:0] a;
    a = desc(4'h1, 3'h0, 64'h100);
    beat(a, 0, {1'b0, 4'h9, 8'h3C, 8'hF1}, 0, 1);
    chk({hdr.addr_offset, hdr.tail_be, hdr.head_be}, 20'h93CF1);
    @(negedge clk) lrdy = 1'b0;
    fork
      u_rrq_user_src.send({16{32'h7777_8888}}, 16'h00FF, 1, '0);
      begin
        repeat (3) @(posedge clk);
        #1;
        chk({rdy, tv}, 2'b01);
        chk(td, a);
        @(negedge clk) lrdy = 1'b1;
      end
    join
    #1;
    chk(tk, 16'h00FF);
    chk({hdr.tail_be, hdr.head_be}, 16'h3CF1);
    $display("test stall done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial
  begin
    arst_n = 1'b0;
    lrdy   = 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    chk({tv, lck}, 2'b00);
    t_msg();
    t_atomic();
    t_abort();
    t_short();
    t_stall();
    u_rrq_user_src.idle();
    summarize();
  end
endmodule
